// ---- rtl/sbc_map.svh ----
// Widths, field positions, delays and timing counts of the core
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
// Functional notes
// RL1 - Activate opens addressed row in selected bank
// RL2 - Controller precharges before opening another row
// RL3 - Read starts burst at column, A10 autoprecharge
// RL4 - Read autoprecharge closes row after burst
// RL5 - Read mask high floats lane two clocks later
// RL6 - Write starts burst at column, A10 autoprecharge
// RL7 - Write stores lane only when mask low
// RL8 - Write autoprecharge closes row after burst
// RL9 - Precharge: A10 high all banks, else one
// RL10 - Controller waits precharge period, activates first
// RL11 - No autoprecharge for full-page bursts
// RL12 - Controller idles bank during autoprecharge period
// RL13 - Burst terminate cuts latest read or write
// RL14 - Controller precharges all before auto refresh
// RL15 - Auto refresh uses internal row counter
// RL16 - Controller sends 4096 refreshes per 64 ms
// RL17 - Refresh with clock enable low enters self refresh
// RL18 - Controller holds self refresh at least tRAS
// RL19 - Controller exits self refresh with NOPs
// RL20 - Controller resumes auto refresh after self refresh
// RL21 - Power cut mode loses data, needs reinit; core returns to normal on cke high with no reinit
// RL22 - Clock enable selects auto or self refresh
// RL23 - Power cut entry: cke,cs low, ras,cas high, we low
// RL24 - Lower mask DQ0-7, upper mask DQ8-15
// RL25 - Per-bank state; idle bank access is illegal
`define SBC_ROW_W        12
`define SBC_COL_W        8
`define SBC_BANKS        4
`define SBC_AP_BIT       10
`define SBC_MASK_DELAY   2
`define SBC_BURST_LEN    4
`define SBC_REFRESH_ROWS 4096
`define SBC_CLK_NS       50
`define SBC_TRFC_NS      70
`define SBC_TRFC_CYC     ((`SBC_TRFC_NS + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
`endif

// ---- rtl/sbc_pkg.sv ----
// Types shared by the bank command core
package sbc_pkg;
  typedef enum logic [3:0] {
    SBC_CMD_NOP   = 4'h0,
    SBC_CMD_ACT   = 4'h1,
    SBC_CMD_RD    = 4'h2,
    SBC_CMD_WR    = 4'h3,
    SBC_CMD_BST   = 4'h4,
    SBC_CMD_PRE   = 4'h5,
    SBC_CMD_AREF  = 4'h6,
    SBC_CMD_SREF  = 4'h7,
    SBC_CMD_LMR   = 4'h8,
    SBC_CMD_PCUT  = 4'h9,
    SBC_CMD_INH   = 4'ha
  } sbc_cmd_t;
  typedef enum logic [1:0] {
    SBC_ST_NORMAL = 2'b00,
    SBC_ST_SELF   = 2'b01,
    SBC_ST_PCUT   = 2'b10
  } sbc_state_t;
  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
  } sbc_ctl_t;
  typedef struct packed {
    logic        open;
    logic [11:0] row;
  } sbc_bank_t;
endpackage

// ---- rtl/sbc_decode.sv ----
// Command decoder from control pins
`timescale 1ns/1ps
`include "sbc_map.svh"
module sbc_decode
  import sbc_pkg::*;
(
  // Pins
  input  wire sbc_ctl_t i_ctl,
  input  wire logic     i_cke_prev,
  // Command
  output sbc_cmd_t      o_cmd
);
  always_comb begin
    o_cmd = SBC_CMD_NOP;
    if (!i_ctl.cke && !i_ctl.cs_n && i_ctl.ras_n && i_ctl.cas_n &&
        !i_ctl.we_n) begin
      o_cmd = SBC_CMD_PCUT; // see RL23
    end else if (!i_ctl.cs_n && !i_ctl.ras_n && !i_ctl.cas_n &&
                 i_ctl.we_n) begin
      o_cmd = i_ctl.cke ? SBC_CMD_AREF : SBC_CMD_SREF; // see RL22
    end else if (i_ctl.cs_n) begin
      o_cmd = SBC_CMD_INH;
    end else if (i_cke_prev) begin
      case ({i_ctl.ras_n, i_ctl.cas_n, i_ctl.we_n})
        3'b011:  o_cmd = SBC_CMD_ACT;
        3'b101:  o_cmd = SBC_CMD_RD;
        3'b100:  o_cmd = SBC_CMD_WR;
        3'b110:  o_cmd = SBC_CMD_BST;
        3'b010:  o_cmd = SBC_CMD_PRE;
        3'b000:  o_cmd = SBC_CMD_LMR;
        default: o_cmd = SBC_CMD_NOP;
      endcase
    end
  end
endmodule // sbc_decode

// ---- rtl/sbc_core.sv ----
// Bank state, burst, masking and refresh logic of the SDRAM core
`timescale 1ns/1ps
`include "sbc_map.svh"
module sbc_core
  import sbc_pkg::*;
#(
  parameter int BURST_LEN = `SBC_BURST_LEN,
  parameter bit FULL_PAGE = 1'b0
)(
  // Clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  // Command pins
  input  wire sbc_ctl_t    i_ctl,
  input  wire logic [1:0]  i_bank,
  input  wire logic [11:0] i_addr,
  input  wire logic        i_lower_byte_mask,
  input  wire logic        i_upper_byte_mask,
  // Data pins
  input  wire logic [15:0] i_dq,
  output logic [15:0]      o_dq,
  output logic [15:0]      o_dq_oe,
  // Array write port
  output logic             o_wr_en,
  output logic [1:0]       o_wr_bank,
  output logic [11:0]      o_wr_row,
  output logic [7:0]       o_wr_col,
  output logic [15:0]      o_wr_data,
  output logic [1:0]       o_wr_lane_en,
  // Array read port data and status
  input  wire logic [15:0] i_rd_data,
  output logic [1:0]       o_rd_bank,
  output logic [11:0]      o_rd_row,
  output logic [7:0]       o_rd_col,
  output logic [3:0]       o_bank_open,
  output logic             o_illegal,
  output logic             o_self_refresh,
  output logic             o_array_power_cut_mode,
  output logic             o_refresh_pulse,
  output logic [11:0]      o_refresh_row
);
  sbc_cmd_t   cmd;
  sbc_bank_t  bank_ff [`SBC_BANKS];
  sbc_bank_t  nxt_bank [`SBC_BANKS];
  sbc_state_t state_ff, nxt_state;
  logic       cke_ff, nxt_cke;
  logic       bact_ff, nxt_bact, bwr_ff, nxt_bwr, bap_ff, nxt_bap;
  logic [1:0] bbank_ff, nxt_bbank;
  logic [7:0] bcol_ff, nxt_bcol;
  logic [8:0] bcnt_ff, nxt_bcnt;
  logic [1:0] rdv_ff, nxt_rdv;
  logic [1:0] m0_ff, nxt_m0, m1_ff, nxt_m1;
  logic [15:0] dq_ff, nxt_dq, oe_ff, nxt_oe;
  logic        wen_ff, nxt_wen, ill_ff, nxt_ill, rf_ff, nxt_rf;
  logic [1:0]  wle_ff, nxt_wle;
  logic [15:0] wd_ff, nxt_wd;
  logic [7:0]  wcol_ff, nxt_wcol;
  logic [1:0]  wbank_ff, nxt_wbank;
  logic [11:0] wrow_ff, nxt_wrow, rcnt_ff, nxt_rcnt;
  logic        last;

  sbc_decode u_decode (
    .i_ctl      (i_ctl),
    .i_cke_prev (cke_ff),
    .o_cmd      (cmd)
  );

  assign last = (bcnt_ff == 9'h001);

  always_comb begin
    for (int b = 0; b < `SBC_BANKS; b++) begin
      nxt_bank[b] = bank_ff[b];
    end
    nxt_state = state_ff;
    nxt_cke   = i_ctl.cke;
    nxt_bact  = bact_ff;
    nxt_bwr   = bwr_ff;
    nxt_bap   = bap_ff;
    nxt_bbank = bbank_ff;
    nxt_bcol  = bcol_ff;
    nxt_bcnt  = bcnt_ff;
    nxt_ill   = 1'b0;
    nxt_rf    = 1'b0;
    nxt_rcnt  = rcnt_ff;
    nxt_wen   = 1'b0;
    nxt_wle   = 2'b00;
    nxt_wd    = wd_ff;
    nxt_wcol  = wcol_ff;
    nxt_wbank = wbank_ff;
    nxt_wrow  = wrow_ff;
    // Burst advance, end and autoprecharge
    if (bact_ff && state_ff == SBC_ST_NORMAL) begin
      if (bwr_ff) begin
        nxt_wen   = 1'b1;
        nxt_wle   = {~i_upper_byte_mask, ~i_lower_byte_mask}; // see RL7 RL24
        nxt_wd    = i_dq;
        nxt_wcol  = bcol_ff;
        nxt_wbank = bbank_ff;
        nxt_wrow  = bank_ff[bbank_ff].row;
      end
      nxt_bcol = bcol_ff + 8'h01;
      if (!FULL_PAGE) begin
        nxt_bcnt = bcnt_ff - 9'h001;
        if (last) begin
          nxt_bact = 1'b0;
          if (bap_ff) begin
            nxt_bank[bbank_ff].open = 1'b0; // see RL4 RL8
          end
        end
      end
    end
    case (state_ff)
      SBC_ST_NORMAL: begin
        case (cmd)
          SBC_CMD_ACT: begin
            nxt_bank[i_bank].open = 1'b1; // see RL1
            nxt_bank[i_bank].row  = i_addr;
          end
          SBC_CMD_RD, SBC_CMD_WR: begin
            if (!bank_ff[i_bank].open) begin
              nxt_ill  = 1'b1; // see RL25
              nxt_bact = 1'b0;
            end else begin
              nxt_bact  = 1'b1; // see RL3 RL6
              nxt_bwr   = (cmd == SBC_CMD_WR);
              nxt_bbank = i_bank;
              nxt_bcol  = i_addr[`SBC_COL_W-1:0];
              nxt_bcnt  = 9'(BURST_LEN);
              nxt_bap   = i_addr[`SBC_AP_BIT] && !FULL_PAGE; // see RL11
            end
          end
          SBC_CMD_BST: nxt_bact = 1'b0; // see RL13
          SBC_CMD_PRE: begin
            for (int b = 0; b < `SBC_BANKS; b++) begin
              if (i_addr[`SBC_AP_BIT] || i_bank == 2'(b)) begin
                nxt_bank[b].open = 1'b0; // see RL9
              end
            end
          end
          SBC_CMD_AREF: begin
            nxt_rf   = 1'b1; // see RL15
            nxt_rcnt = rcnt_ff + 12'h001;
          end
          SBC_CMD_SREF: begin
            nxt_state = SBC_ST_SELF; // see RL17
            nxt_bact  = 1'b0;
          end
          SBC_CMD_PCUT: begin
            nxt_state = SBC_ST_PCUT; // see RL21
            nxt_bact  = 1'b0;
            for (int b = 0; b < `SBC_BANKS; b++) begin
              nxt_bank[b].open = 1'b0;
            end
          end
          default: ;
        endcase
      end
      SBC_ST_SELF: begin
        nxt_rf   = 1'b1; // see RL17
        nxt_rcnt = rcnt_ff + 12'h001;
        if (i_ctl.cke) begin
          nxt_state = SBC_ST_NORMAL;
        end
      end
      SBC_ST_PCUT: begin
        if (i_ctl.cke) begin
          nxt_state = SBC_ST_NORMAL; // see RL21
        end
      end
      default: nxt_state = SBC_ST_NORMAL;
    endcase
  end

  // Read data pipeline and two-clock mask delay
  always_comb begin
    nxt_rdv = {rdv_ff[0], bact_ff && !bwr_ff && state_ff == SBC_ST_NORMAL};
    nxt_m0  = {i_upper_byte_mask, i_lower_byte_mask};
    nxt_m1  = m0_ff;
    nxt_dq  = i_rd_data;
    // Enable lines up with the beat now in the data register
    nxt_oe  = {{8{nxt_rdv[0] && !m1_ff[1]}},
               {8{nxt_rdv[0] && !m1_ff[0]}}}; // see RL5 RL24
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      for (int b = 0; b < `SBC_BANKS; b++) begin
        bank_ff[b] <= '0;
      end
      state_ff <= SBC_ST_NORMAL;
      cke_ff   <= 1'b0;
      bact_ff  <= 1'b0;
      bwr_ff   <= 1'b0;
      bap_ff   <= 1'b0;
      bbank_ff <= 2'h0;
      bcol_ff  <= 8'h00;
      bcnt_ff  <= 9'h000;
      rdv_ff   <= 2'h0;
      m0_ff    <= 2'h3;
      m1_ff    <= 2'h3;
      dq_ff    <= 16'h0000;
      oe_ff    <= 16'h0000;
      wen_ff   <= 1'b0;
      wle_ff   <= 2'h0;
      wd_ff    <= 16'h0000;
      wcol_ff  <= 8'h00;
      wbank_ff <= 2'h0;
      wrow_ff  <= 12'h000;
      ill_ff   <= 1'b0;
      rf_ff    <= 1'b0;
      rcnt_ff  <= 12'h000;
    end else begin
      bank_ff  <= nxt_bank;
      state_ff <= nxt_state;
      cke_ff   <= nxt_cke;
      bact_ff  <= nxt_bact;
      bwr_ff   <= nxt_bwr;
      bap_ff   <= nxt_bap;
      bbank_ff <= nxt_bbank;
      bcol_ff  <= nxt_bcol;
      bcnt_ff  <= nxt_bcnt;
      rdv_ff   <= nxt_rdv;
      m0_ff    <= nxt_m0;
      m1_ff    <= nxt_m1;
      dq_ff    <= nxt_dq;
      oe_ff    <= nxt_oe;
      wen_ff   <= nxt_wen;
      wle_ff   <= nxt_wle;
      wd_ff    <= nxt_wd;
      wcol_ff  <= nxt_wcol;
      wbank_ff <= nxt_wbank;
      wrow_ff  <= nxt_wrow;
      ill_ff   <= nxt_ill;
      rf_ff    <= nxt_rf;
      rcnt_ff  <= nxt_rcnt;
    end
  end

  assign o_dq         = dq_ff;
  assign o_dq_oe      = oe_ff;
  assign o_wr_en      = wen_ff;
  assign o_wr_bank    = wbank_ff;
  assign o_wr_row     = wrow_ff;
  assign o_wr_col     = wcol_ff;
  assign o_wr_data    = wd_ff;
  assign o_wr_lane_en = wle_ff;
  assign o_rd_bank    = bbank_ff;
  assign o_rd_row     = bank_ff[bbank_ff].row;
  assign o_rd_col     = bcol_ff;
  assign o_illegal    = ill_ff;
  assign o_self_refresh         = (state_ff == SBC_ST_SELF);
  assign o_array_power_cut_mode = (state_ff == SBC_ST_PCUT);
  assign o_refresh_pulse        = rf_ff;
  assign o_refresh_row          = rcnt_ff;

  genvar g;
  generate
    for (g = 0; g < `SBC_BANKS; g++) begin : g_open
      assign o_bank_open[g] = bank_ff[g].open;
    end
  endgenerate

  sequence s_act;
    cmd == SBC_CMD_ACT && state_ff == SBC_ST_NORMAL;
  endsequence
  property p_act_open;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_act |=> bank_ff[$past(i_bank)].open;
  endproperty
  a_act_open: assert property (p_act_open) else $error("row not opened"); // see RL1
  property p_rd_idle;
    @(posedge i_clk_sys) disable iff (i_reset)
      (cmd == SBC_CMD_RD && state_ff == SBC_ST_NORMAL &&
       !bank_ff[i_bank].open) |=> o_illegal && !bact_ff;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle read not flagged"); // see RL25
  property p_mask_rd;
    @(posedge i_clk_sys) disable iff (i_reset)
      i_upper_byte_mask |-> ##2 !o_dq_oe[8];
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("masked lane driven"); // see RL5
  property p_mask_wr;
    @(posedge i_clk_sys) disable iff (i_reset)
      (bact_ff && bwr_ff && state_ff == SBC_ST_NORMAL && i_upper_byte_mask)
        |=> o_wr_en && !o_wr_lane_en[1];
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("masked byte written"); // see RL7
  property p_pre_all;
    @(posedge i_clk_sys) disable iff (i_reset)
      (cmd == SBC_CMD_PRE && state_ff == SBC_ST_NORMAL &&
       i_addr[`SBC_AP_BIT]) |=> o_bank_open == 4'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all failed"); // see RL9
  property p_bst;
    @(posedge i_clk_sys) disable iff (i_reset)
      (cmd == SBC_CMD_BST && state_ff == SBC_ST_NORMAL) |=> !bact_ff;
  endproperty
  a_bst: assert property (p_bst) else $error("burst not stopped"); // see RL13
  property p_aref;
    @(posedge i_clk_sys) disable iff (i_reset)
      (cmd == SBC_CMD_AREF && state_ff == SBC_ST_NORMAL)
        |=> o_refresh_pulse && o_refresh_row == $past(rcnt_ff) + 12'h001;
  endproperty
  a_aref: assert property (p_aref) else $error("refresh row wrong"); // see RL15
  property p_sref;
    @(posedge i_clk_sys) disable iff (i_reset)
      (cmd == SBC_CMD_SREF && state_ff == SBC_ST_NORMAL) |=> o_self_refresh;
  endproperty
  a_sref: assert property (p_sref) else $error("self refresh not entered"); // see RL17
  property p_pcut;
    @(posedge i_clk_sys) disable iff (i_reset)
      (cmd == SBC_CMD_PCUT && state_ff == SBC_ST_NORMAL)
        |=> o_array_power_cut_mode && o_bank_open == 4'h0;
  endproperty
  a_pcut: assert property (p_pcut) else $error("power cut not entered"); // see RL21 RL23
  property p_ap;
    @(posedge i_clk_sys) disable iff (i_reset)
      (bact_ff && last && bap_ff && state_ff == SBC_ST_NORMAL &&
       cmd != SBC_CMD_ACT) |=> !bank_ff[$past(bbank_ff)].open;
  endproperty
  a_ap: assert property (p_ap) else $error("autoprecharge missed"); // see RL4 RL8
endmodule // sbc_core

// ---- verification/sbc_array_model.sv ----
// Behavioural memory array behind the core's array ports
`timescale 1ns/1ps
module sbc_array_model (
  // Clock
  input  wire logic        i_clk_sys,
  // Write port
  input  wire logic        i_wr_en,
  input  wire logic [21:0] i_wr_addr,
  input  wire logic [15:0] i_wr_data,
  input  wire logic [1:0]  i_wr_lane_en,
  // Read port
  input  wire logic [21:0] i_rd_addr,
  output logic [15:0]      o_rd_data
);
  logic [15:0] mem [logic [21:0]];
  function automatic logic [15:0] peek(input logic [21:0] a);
    return mem.exists(a) ? mem[a] : 16'h0000;
  endfunction
  function automatic logic [15:0] merge(input logic [15:0] o, d,
                                        input logic [1:0] e);
    return {e[1] ? d[15:8] : o[15:8], e[0] ? d[7:0] : o[7:0]};
  endfunction
  assign o_rd_data = peek(i_rd_addr);
  always @(posedge i_clk_sys) begin
    if (i_wr_en === 1'b1) begin
      mem[i_wr_addr] = merge(peek(i_wr_addr), i_wr_data, i_wr_lane_en);
    end
  end
endmodule // sbc_array_model

// ---- verification/sbc_core_bench.sv ----
// Self-checking bench of the bank command core
`timescale 1ns/1ps
module sbc_core_bench;
  import sbc_pkg::*;
  logic        clk, rst, lm, um;
  sbc_ctl_t    ctl;
  logic [1:0]  bank, wr_bank, rd_bank, wr_lane;
  logic [11:0] addr, wr_row, rd_row, ref_row, exp_row, r0;
  logic [7:0]  wr_col, rd_col, exp_col;
  logic [15:0] dq, o_dq, o_oe, wr_data, rd_data, exp_oe, first_dq;
  logic [3:0]  bank_open;
  logic        wr_en, illegal, self_ref, pcut, ref_p;
  int          mismatches, n_tests, wr_n, rd_n, ill_n, ref_n;

  sbc_core sbc_core_i (
    .i_clk_sys(clk), .i_reset(rst), .i_ctl(ctl), .i_bank(bank),
    .i_addr(addr), .i_lower_byte_mask(lm), .i_upper_byte_mask(um),
    .i_dq(dq), .o_dq(o_dq), .o_dq_oe(o_oe), .o_wr_en(wr_en),
    .o_wr_bank(wr_bank), .o_wr_row(wr_row), .o_wr_col(wr_col),
    .o_wr_data(wr_data), .o_wr_lane_en(wr_lane), .i_rd_data(rd_data),
    .o_rd_bank(rd_bank), .o_rd_row(rd_row), .o_rd_col(rd_col),
    .o_bank_open(bank_open), .o_illegal(illegal),
    .o_self_refresh(self_ref), .o_array_power_cut_mode(pcut),
    .o_refresh_pulse(ref_p), .o_refresh_row(ref_row)
  );
  sbc_array_model sbc_array_model_i (
    .i_clk_sys(clk), .i_wr_en(wr_en),
    .i_wr_addr({wr_bank, wr_row, wr_col}), .i_wr_data(wr_data),
    .i_wr_lane_en(wr_lane), .i_rd_addr({rd_bank, rd_row, rd_col}),
    .o_rd_data(rd_data)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic chk(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Watches the array write port and the read drive enables
  always @(posedge clk) begin
    if (wr_en === 1'b1) begin
      chk(wr_col, 8'(exp_col + wr_n));
      chk(wr_row, exp_row);
      wr_n++;
    end
    if (o_oe !== 16'h0000) begin
      if (rd_n == 0) first_dq = o_dq;
      chk(o_oe, exp_oe);
      rd_n++;
    end
    ill_n += (illegal === 1'b1);
    ref_n += (ref_p === 1'b1);
  end

  task automatic cmd(input logic [4:0] c, input logic [1:0] b,
                     input logic [11:0] a);
    @(posedge clk);
    #1;
    ctl = c;
    bank = b;
    addr = a;
  endtask
  task automatic nop(input int n);
    repeat (n) cmd(5'h17, 2'd0, 12'h000);
  endtask
  task automatic beat(input logic [15:0] d, input logic l, u);
    nop(1);
    dq = d;
    lm = l;
    um = u;
  endtask

  task automatic t_illegal();
    ill_n = 0;
    rd_n = 0;
    cmd(5'h15, 2'd2, 12'h000);
    nop(8);
    chk(ill_n, 1);
    chk(rd_n, 0);
  endtask

  task automatic t_write();
    exp_row = 12'h123;
    exp_col = 8'h10;
    wr_n = 0;
    cmd(5'h13, 2'd1, 12'h123);
    nop(1);
    chk(bank_open, 4'h2);
    cmd(5'h14, 2'd1, 12'h410);
    beat(16'h1111, 1'b0, 1'b0);
    beat(16'h2222, 1'b1, 1'b0);
    beat(16'h3333, 1'b0, 1'b0);
    beat(16'h4444, 1'b0, 1'b1);
    nop(1);
    lm = 1'b0;
    um = 1'b0;
    nop(4);
    chk(wr_n, 4);
    chk(sbc_array_model_i.peek(22'h112311), 16'h2200);
    chk(sbc_array_model_i.peek(22'h112313), 16'h0044);
    chk(sbc_array_model_i.peek(22'h112312), 16'h3333);
    chk(bank_open, 4'h0);
  endtask

  task automatic t_bst();
    um = 1'b1;
    exp_oe = 16'h00ff;
    cmd(5'h13, 2'd1, 12'h123);
    nop(1);
    rd_n = 0;
    cmd(5'h15, 2'd1, 12'h010);
    cmd(5'h16, 2'd0, 12'h000);
    nop(8);
    chk(rd_n < 4, 1'b1);
  endtask

  task automatic t_read(input logic ap);
    rd_n = 0;
    cmd(5'h15, 2'd1, {1'b0, ap, 10'h010});
    nop(10);
    chk(rd_n, 4);
    chk(first_dq[7:0], 8'h11);
    chk(bank_open[1], !ap);
  endtask

  task automatic t_precharge();
    cmd(5'h13, 2'd0, 12'h005);
    cmd(5'h13, 2'd3, 12'h007);
    nop(1);
    chk(bank_open, 4'h9);
    cmd(5'h12, 2'd0, 12'h000);
    nop(1);
    chk(bank_open, 4'h8);
    cmd(5'h12, 2'd2, 12'h400);
    nop(3);
    chk(bank_open, 4'h0);
  endtask

  task automatic t_refresh();
    r0 = ref_row;
    ref_n = 0;
    cmd(5'h11, 2'd3, 12'hfff);
    nop(3);
    chk(ref_n, 1);
    chk(ref_row, r0 + 12'h001);
    cmd(5'h01, 2'd0, 12'h000);
    repeat (4) cmd(5'h07, 2'd0, 12'h000);
    chk(self_ref, 1'b1);
    nop(3);
    chk(self_ref, 1'b0);
  endtask

  task automatic t_power_cut();
    cmd(5'h06, 2'd0, 12'h000);
    repeat (2) cmd(5'h07, 2'd0, 12'h000);
    chk(pcut, 1'b1);
    nop(3);
    chk(pcut, 1'b0);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {ctl, bank, addr, lm, um, dq} = '0;
    {exp_col, exp_row, exp_oe, first_dq} = '0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    ctl = 5'h17;
    nop(2);
    chk(bank_open, 4'h0);
    chk(o_oe, 16'h0000);
    t_illegal();
    t_write();
    t_bst();
    t_read(1'b0);
    t_read(1'b1);
    um = 1'b0;
    t_precharge();
    t_refresh();
    t_power_cut();
    give_verdict();
  end
endmodule // sbc_core_bench
